// file: logic/amrc_code_fmt.sv
// Result coding with saturation
`timescale 1ns/1ns
`include "amrc_consts.svh"
module amrc_code_fmt #(
   parameter int CODE_W = `AMRC_CODE_W
) (
   input amrc_pkg::amrc_sample_t sample_i,
   input wire logic twos_comp_i,
   output logic [CODE_W-1:0] code_o
);
   logic [CODE_W-1:0] sb;
   always_comb begin
      // Clamp rather than wrap
      if (sample_i.over) begin
         sb = `AMRC_MAX_SB;
      end else if (sample_i.under) begin
         sb = `AMRC_MIN_SB;
      end else begin
         sb = sample_i.raw;
      end
      code_o = sb;
      if (twos_comp_i) begin
         code_o[CODE_W-1] = ~sb[CODE_W-1];
      end
   end
endmodule // amrc_code_fmt

// file: logic/amrc_setup_dec.sv
// Decoder of mode, range and coding from pins or configuration
`timescale 1ns/1ns
`include "amrc_consts.svh"
module amrc_setup_dec (
   input wire logic sw_ctrl_i,
   input wire logic [15:0] cfg_i,
   input wire logic fast_sel_i,
   input wire logic lowp_sel_i,
   input wire logic code_format_select_i,
   input wire logic bipolar_select_i,
   input wire logic wide_span_select_i,
   output amrc_pkg::amrc_setup_t setup_o
);
   function automatic amrc_pkg::amrc_mode_t mode_of(input logic f,
                                                    input logic l);
      if (f && !l) begin
         mode_of = amrc_pkg::AMRC_MODE_FAST;
      end else if (!f && l) begin
         mode_of = amrc_pkg::AMRC_MODE_LOWP;
      end else begin
         mode_of = amrc_pkg::AMRC_MODE_NORMAL;
      end
   endfunction

   always_comb begin
      if (sw_ctrl_i) begin
         // Pins are don't-care here
         setup_o.twos_comp = ~cfg_i[`AMRC_CFG_FMT_BIT];
         setup_o.range.bipolar = cfg_i[`AMRC_CFG_BIP_BIT];
         setup_o.range.wide_span = cfg_i[`AMRC_CFG_TEN_BIT];
         setup_o.mode = mode_of(cfg_i[`AMRC_CFG_FAST_BIT],
                                cfg_i[`AMRC_CFG_LOWP_BIT]);
      end else begin
         // Format pin high means straight binary
         setup_o.twos_comp = ~code_format_select_i;
         setup_o.range.bipolar = bipolar_select_i;
         setup_o.range.wide_span = wide_span_select_i;
         setup_o.mode = mode_of(fast_sel_i, lowp_sel_i);
      end
   end
endmodule // amrc_setup_dec

// file: logic/amrc_top.sv
// Mode, range and output-code control of the converter core
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "amrc_consts.svh"
module amrc_top #(
   parameter int GAP_CYC = `AMRC_GAP_CYC,
   parameter int SAR_CYC = `AMRC_SAR_CYC
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [3:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic conversion_start_n_i,
   input wire logic fast_sel_i,
   input wire logic lowp_sel_i,
   input wire logic code_format_select_i,
   input wire logic bipolar_select_i,
   input wire logic wide_span_select_i,
   input amrc_pkg::amrc_sample_t sample_i,
   output logic busy_o,
   output logic [13:0] code_o,
   output logic conv_power_o,
   output logic result_suspect_o,
   output amrc_pkg::amrc_setup_t setup_o
);
   typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_REST} amrc_state_t;

   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [15:0] cfg, next_cfg;
   logic [15:0] rdata, next_rdata;
   amrc_pkg::amrc_setup_t setup_now;

   amrc_setup_dec u_dec (
      .sw_ctrl_i(cfg[`AMRC_CFG_SW_BIT]),
      .cfg_i(cfg),
      .fast_sel_i(fast_sel_i),
      .lowp_sel_i(lowp_sel_i),
      .code_format_select_i(code_format_select_i),
      .bipolar_select_i(bipolar_select_i),
      .wide_span_select_i(wide_span_select_i),
      .setup_o(setup_now)
   );

   // ----------------------------------------
   // Conversion sequencer
   // ----------------------------------------
   amrc_state_t state, next_state;
   logic [15:0] cnt, next_cnt;
   logic [31:0] gap, next_gap;
   logic prev_start, next_prev_start;
   logic busy, next_busy;
   logic power, next_power;
   logic suspect, next_suspect;
   logic [13:0] code, next_code;
   amrc_pkg::amrc_setup_t setup_q, next_setup;
   logic [13:0] fmt_code;
   logic [15:0] period;

   amrc_code_fmt #(.CODE_W(14)) u_fmt (
      .sample_i(sample_i),
      .twos_comp_i(setup_q.twos_comp),
      .code_o(fmt_code)
   );

   // Least spacing between starts per mode
   always_comb begin
      case (setup_q.mode)
         amrc_pkg::AMRC_MODE_FAST: period = 16'(`AMRC_CYC(`AMRC_FAST_KSPS));
         amrc_pkg::AMRC_MODE_LOWP: period = 16'(`AMRC_CYC(`AMRC_LOWP_KSPS));
         default: period = 16'(`AMRC_CYC(`AMRC_NORM_KSPS));
      endcase
   end

   always_comb begin
      next_prev_start = conversion_start_n_i;
      next_state = state;
      next_cnt = cnt;
      next_busy = busy;
      next_power = power;
      next_code = code;
      next_suspect = suspect;
      next_setup = setup_q;
      next_gap = (gap < 32'(GAP_CYC)) ? gap + 32'h1 : gap;
      case (state)
         ST_IDLE: begin
            if (prev_start && !conversion_start_n_i) begin
               // Setup latched at start; pin changes affect next sample
               next_setup = setup_now;
               next_state = ST_CONV;
               next_cnt = 16'h0;
               next_busy = 1'b1;
               next_power = 1'b1;
               // Long idle in fast mode leaves first result offset
               next_suspect = (setup_now.mode == amrc_pkg::AMRC_MODE_FAST)
                  && (gap >= 32'(GAP_CYC));
               next_gap = 32'h0;
            end
         end
         ST_CONV: begin
            next_cnt = cnt + 16'h1;
            if (cnt == 16'(SAR_CYC - 1)) begin
               next_code = fmt_code;
               next_busy = 1'b0;
               if (setup_q.mode == amrc_pkg::AMRC_MODE_LOWP) begin
                  next_power = 1'b0;
               end
               next_state = ST_REST;
            end
         end
         ST_REST: begin
            // Starts too early are ignored, capping throughput
            next_cnt = cnt + 16'h1;
            if (cnt >= period - 16'h1) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_comb begin
      next_cfg = cfg;
      next_rdata = 16'h0;
      if (wr_i && addr_i == `AMRC_ADDR_CFG) begin
         next_cfg = {10'h0, wdata_i[5:0]};
      end
      if (rd_i) begin
         case (addr_i)
            `AMRC_ADDR_CFG: next_rdata = cfg;
            `AMRC_ADDR_STAT: next_rdata = {8'h0, suspect, power, busy,
               setup_q.twos_comp, setup_q.range, setup_q.mode};
            `AMRC_ADDR_CODE: next_rdata = {2'h0, code};
            default: next_rdata = 16'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         cnt <= 16'h0;
         gap <= 32'h0;
         prev_start <= 1'b1;
         busy <= 1'b0;
         power <= 1'b1;
         suspect <= 1'b0;
         code <= 14'h0;
         setup_q <= '0;
         cfg <= `AMRC_CFG_RESET;
         rdata <= 16'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         gap <= next_gap;
         prev_start <= next_prev_start;
         busy <= next_busy;
         power <= next_power;
         suspect <= next_suspect;
         code <= next_code;
         setup_q <= next_setup;
         cfg <= next_cfg;
         rdata <= next_rdata;
      end
   end

   assign rdata_o = rdata;
   assign busy_o = busy;
   assign code_o = code;
   assign conv_power_o = power;
   assign result_suspect_o = suspect;
   assign setup_o = setup_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_conv_start;
      state == ST_IDLE && prev_start && !conversion_start_n_i;
   endsequence

   a_busy_after_start: assert property (@(posedge core_clk_i)
      disable iff (rst_i) s_conv_start |=> busy)
      else $error("busy not raised after start");
   a_busy_ends: assert property (@(posedge core_clk_i)
      disable iff (rst_i) s_conv_start |=> ##[1:300] !busy)
      else $error("busy never dropped");
   a_lowp_power_off: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ($fell(busy) && setup_q.mode ==
         amrc_pkg::AMRC_MODE_LOWP) |-> !power)
      else $error("low-power mode kept power on");
   a_power_in_conv: assert property (@(posedge core_clk_i)
      disable iff (rst_i) busy |-> power)
      else $error("converting while powered down");
   a_fmt_pin_ignored: assert property (@(posedge core_clk_i)
      disable iff (rst_i) cfg[`AMRC_CFG_SW_BIT] |->
      setup_now.twos_comp == ~cfg[`AMRC_CFG_FMT_BIT])
      else $error("format pin not ignored");
   a_range_pins: assert property (@(posedge core_clk_i)
      disable iff (rst_i) !cfg[`AMRC_CFG_SW_BIT] |->
      setup_now.range == {bipolar_select_i, wide_span_select_i})
      else $error("range pins not applied");
   a_range_cfg: assert property (@(posedge core_clk_i)
      disable iff (rst_i) cfg[`AMRC_CFG_SW_BIT] |->
      setup_now.range == {cfg[`AMRC_CFG_BIP_BIT],
      cfg[`AMRC_CFG_TEN_BIT]})
      else $error("range pins not ignored");
   a_sat_high: assert property (@(posedge core_clk_i)
      disable iff (rst_i) (state == ST_CONV && next_state == ST_REST &&
      sample_i.over) |=> code == (setup_q.twos_comp ? 14'h1fff :
      14'h3fff))
      else $error("overrange not saturated");
   a_twos_comp: assert property (@(posedge core_clk_i)
      disable iff (rst_i) (state == ST_CONV && next_state == ST_REST &&
      sample_i.under && setup_q.twos_comp) |=> code == 14'h2000)
      else $error("twos complement floor wrong");
   a_fast_spacing: assert property (@(posedge core_clk_i)
      disable iff (rst_i) ($fell(busy) && setup_q.mode ==
      amrc_pkg::AMRC_MODE_FAST) |-> state != ST_IDLE [*8])
      else $error("fast mode restarted too soon");
endmodule // amrc_top

// file: shared/amrc_consts.svh
// Constants for the converter mode, range and code-format block
// Functional notes
// - Fast low and low-power high selects low-power mode, at most 670 kSPS.
// - Low-power mode powers conversion circuits down after each conversion.
// - Results coded straight binary or twos complement, by pin or register.
// - Register control of coding makes the format pin ignored.
// - 14-bit codes; twos complement is straight binary with top bit inverted.
// - Over- or under-range input saturates to the largest or smallest code.
// - Two pins pick bipolar and ten-volt span, giving four input ranges.
// - Register control of range makes both range pins ignored.
// - Both mode selectors equal gives normal mode up to 800 kSPS.
// - Fast high, low-power low gives fastest mode, 1 MSPS; gap over 1 ms flags.
// - When approximation completes, code is produced and busy goes low.
`ifndef AMRC_CONSTS_SVH
`define AMRC_CONSTS_SVH

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define AMRC_ADDR_CFG 4'h0
`define AMRC_ADDR_STAT 4'h1
`define AMRC_ADDR_CODE 4'h2
`define AMRC_CFG_RESET 16'h0000
`define AMRC_CFG_SW_BIT 0
`define AMRC_CFG_FMT_BIT 1
`define AMRC_CFG_BIP_BIT 2
`define AMRC_CFG_TEN_BIT 3
`define AMRC_CFG_FAST_BIT 4
`define AMRC_CFG_LOWP_BIT 5

// ----------------------------------------
// Codes and timing
// ----------------------------------------
`define AMRC_CODE_W 14
`define AMRC_MID_CODE 14'h2000
`define AMRC_MAX_SB 14'h3fff
`define AMRC_MIN_SB 14'h0000
`define AMRC_CLK_MHZ 50
`define AMRC_FAST_KSPS 1000
`define AMRC_NORM_KSPS 800
`define AMRC_LOWP_KSPS 670
`define AMRC_GAP_MS 1
// Least cycles per conversion: rounds up
`define AMRC_CYC(k) ((`AMRC_CLK_MHZ * 1000 + (k) - 1) / (k))
`define AMRC_GAP_CYC (`AMRC_GAP_MS * `AMRC_CLK_MHZ * 1000)
`define AMRC_SAR_CYC 40

`endif

// file: shared/amrc_pkg.sv
// Types for the converter mode, range and code-format block
package amrc_pkg;
   typedef enum logic [1:0] {
      AMRC_MODE_NORMAL,
      AMRC_MODE_FAST,
      AMRC_MODE_LOWP
   } amrc_mode_t;

   typedef struct packed {
      logic bipolar;
      logic wide_span;
   } amrc_range_t;

   typedef struct packed {
      logic twos_comp;
      amrc_range_t range;
      amrc_mode_t mode;
   } amrc_setup_t;

   typedef struct packed {
      logic over;
      logic under;
      logic [13:0] raw;
   } amrc_sample_t;
endpackage

// file: test/amrc_host_model.sv
// Host controller model driving selector pins and conversion start
`timescale 1ns/1ns
module amrc_host_model (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [4:0] sel_i,
   output logic conversion_start_n_o,
   output logic fast_sel_o,
   output logic lowp_sel_o,
   output logic code_format_select_o,
   output logic bipolar_select_o,
   output logic wide_span_select_o
);
   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   // Pins keep following sel_i even while the register rules them
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         conversion_start_n_o <= 1'b1;
         {fast_sel_o, lowp_sel_o, code_format_select_o} <= 3'h0;
         {bipolar_select_o, wide_span_select_o} <= 2'h0;
      end else begin
         conversion_start_n_o <= !go_i;
         {fast_sel_o, lowp_sel_o, code_format_select_o} <= sel_i[4:2];
         {bipolar_select_o, wide_span_select_o} <= sel_i[1:0];
      end
   end
endmodule // amrc_host_model

// file: test/amrc_top_tb.sv
// Self-checking bench of the mode, range and code-format block
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module amrc_top_tb;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic go = 1'b0;
   logic [4:0] sel = 5'h00;
   amrc_pkg::amrc_sample_t sample_i = '0;
   logic [15:0] rdata_o;
   logic start_n, fast, lowp, fmt, bip, wide, busy_o, conv_power_o, suspect;
   logic [13:0] code_o;
   amrc_pkg::amrc_setup_t setup_o;
   int failures = 0;
   int check_count = 0;
   int n;
   amrc_pkg::amrc_mode_t emode [4] = '{amrc_pkg::AMRC_MODE_NORMAL,
      amrc_pkg::AMRC_MODE_LOWP, amrc_pkg::AMRC_MODE_FAST,
      amrc_pkg::AMRC_MODE_NORMAL};
   logic [15:0] smp_t [6] = '{16'h2000, 16'h2000, 16'h9234, 16'h9234,
      16'h5234, 16'h5234};
   logic [13:0] exp_t [6] = '{14'h2000, 14'h0000, 14'h3fff, 14'h1fff,
      14'h0000, 14'h2000};

   // ----------------------------------------
   // Design and host
   // ----------------------------------------
   // Short idle limit keeps the stale-result case quick
   amrc_top #(.GAP_CYC(200), .SAR_CYC(40)) i_dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .conversion_start_n_i(start_n), .fast_sel_i(fast),
      .lowp_sel_i(lowp), .code_format_select_i(fmt),
      .bipolar_select_i(bip), .wide_span_select_i(wide),
      .sample_i(sample_i), .busy_o(busy_o), .code_o(code_o),
      .conv_power_o(conv_power_o), .result_suspect_o(suspect),
      .setup_o(setup_o));
   amrc_host_model i_host (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .go_i(go), .sel_i(sel),
      .conversion_start_n_o(start_n), .fast_sel_o(fast),
      .lowp_sel_o(lowp), .code_format_select_o(fmt),
      .bipolar_select_o(bip), .wide_span_select_o(wide));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge core_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
      @(posedge core_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1;
      `CHK("rdata", e, rdata_o)
   endtask

   task automatic conv(input logic [4:0] s, input logic [15:0] smp,
                       input logic [13:0] e);
      @(posedge core_clk_i);
      sel <= s;
      sample_i <= smp;
      repeat (2) @(posedge core_clk_i);
      go <= 1'b1;
      @(posedge core_clk_i);
      go <= 1'b0;
      n = 0;
      while (busy_o !== 1'b1 && n < 10) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      `CHK("busy", 1'b1, busy_o)
      `CHK("power_busy", 1'b1, conv_power_o)
      n = 0;
      while (busy_o === 1'b1 && n < 100) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      `CHK("sar_cycles", 40, n)
      `CHK("code", e, code_o)
      // Longest mode period is covered before the next start
      repeat (40) @(posedge core_clk_i);
   endtask

   task automatic finish_test;
      if (failures == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Clock, watchdog and tests
   // ----------------------------------------
   initial begin
      forever #10 core_clk_i = ~core_clk_i;
   end

   initial begin
      #400000;
      failures++;
      finish_test;
   end

   initial begin
      repeat (5) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #1;
      `CHK("power_rst", 1'b1, conv_power_o)
      `CHK("busy_rst", 1'b0, busy_o)
      rd_chk(4'h0, 16'h0000);
      rd_chk(4'h7, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         conv({i[1:0], 3'b100}, 16'h2000, 14'h2000);
         `CHK("mode", emode[i], setup_o.mode)
         `CHK("lowp_power", i != 1, conv_power_o)
      end
      for (int i = 0; i < 4; i++) begin
         conv({3'b001, i[1:0]}, 16'h0001, 14'h0001);
         `CHK("range", i[1:0], setup_o.range)
      end
      for (int i = 0; i < 6; i++) begin
         conv({2'b00, !i[0], 2'b00}, smp_t[i], exp_t[i]);
      end
      rd_chk(4'h2, 16'h2000);
      wr(4'h0, 16'h001d);
      rd_chk(4'h0, 16'h001d);
      conv(5'b01100, 16'h2000, 14'h0000);
      `CHK("sw_setup", 5'b11101, setup_o)
      rd_chk(4'h1, 16'h005d);
      rd_chk(4'h2, 16'h0000);
      wr(4'h0, 16'h0000);
      conv(5'b10100, 16'h2000, 14'h2000);
      repeat (250) @(posedge core_clk_i);
      conv(5'b10100, 16'h2000, 14'h2000);
      `CHK("suspect_gap", 1'b1, suspect)
      conv(5'b10100, 16'h2000, 14'h2000);
      `CHK("suspect_back", 1'b0, suspect)
      // Mid-run reset must clear the latched result and setup
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #1;
      `CHK("code_rst", 14'h0000, code_o)
      `CHK("setup_rst", 5'b00000, setup_o)
      `CHK("suspect_rst", 1'b0, suspect)
      rd_chk(4'h0, 16'h0000);
      conv(5'b00100, 16'h2001, 14'h2001);
      finish_test;
   end
endmodule // amrc_top_tb
